/* File: rtl/flash_seq_pkg.sv */
// constants, register map and types of the flash write/erase sequencer
package flash_seq_pkg;
    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int ERASE_TIME_US = 12000;
    localparam int WRITE_TIME_NS = 50000;
    localparam logic [23:0] ERASE_CYCLES = 24'(ERASE_TIME_US * CLK_MHZ);
    localparam logic [23:0] WRITE_CYCLES = 24'((WRITE_TIME_NS * CLK_MHZ + 999) / 1000);
    localparam int CNT_W = 24;

    // -----------------------------------------------------------------
    // register offsets (byte addresses)
    // -----------------------------------------------------------------
    localparam logic [7:0] OFS_PROGRAM_STORE_CONTROL = 8'h00;
    localparam logic [7:0] OFS_SCALE = 8'h04;
    localparam logic [7:0] OFS_CACHE = 8'h08;
    localparam logic [7:0] OFS_BANK = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_ERASE_CNT = 8'h14;
    localparam logic [7:0] OFS_WRITE_CNT = 8'h18;

    // -----------------------------------------------------------------
    // field positions and reset values
    // -----------------------------------------------------------------
    localparam int REDIRECT_BIT = 0;
    localparam int ERASE_EN_BIT = 1;
    localparam int SCRATCH_BIT = 2;
    localparam int SW_WE_BIT = 0;
    localparam int BLOCK_BIT = 0;
    localparam int BANK_LSB = 4;
    localparam int BUSY_BIT = 0;
    localparam logic [2:0] PROGRAM_STORE_CONTROL_RST = 3'h0;
    localparam logic SW_WE_RST = 1'b0;
    localparam logic BLOCK_RST = 1'b0;
    localparam logic [1:0] BANK_RST = 2'h1;

    // -----------------------------------------------------------------
    // flash address space
    // -----------------------------------------------------------------
    localparam logic [17:0] SCRATCH_BASE = 18'h20000;
    localparam logic [7:0] SCRATCH_HI = 8'h00;
    localparam logic [15:0] BOTH_PAGES_ADDR = 16'h0400;
    localparam logic [17:0] MAIN_PAGE_MASK = 18'h3fc00;
    localparam logic [17:0] SCRATCH_PAGE_MASK = 18'h3ff80;
    localparam logic [17:0] WORD_MASK = 18'h3fffc;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ERASE = 2'b01,
        ST_PROG = 2'b10
    } state_t;
endpackage

/* File: rtl/op_timer_if.sv */
// carrier between the sequencer and its operation timer
`timescale 1ns/1ps
interface op_timer_if;
    logic start;
    logic [23:0] cycles;
    logic busy;
    logic done;
    modport seq (output start, output cycles, input busy, input done);
    modport timer (input start, input cycles, output busy, output done);
endinterface

/* File: rtl/op_timer.sv */
// cycle counter that times one erase or programming pulse
`timescale 1ns/1ps
module op_timer (
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    op_timer_if.timer tmr
);
    import flash_seq_pkg::*;

    logic busy_reg;
    logic [CNT_W-1:0] cnt_reg;

    // -----------------------------------------------------------------
    // countdown: busy for exactly cycles clocks, zero counts as one
    // -----------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            busy_reg <= 1'b0;
            cnt_reg <= '0;
        end else if (tmr.start && !busy_reg) begin
            busy_reg <= 1'b1;
            cnt_reg <= (tmr.cycles == '0) ? CNT_W'(1) : tmr.cycles;
        end else if (tmr.done) begin
            busy_reg <= 1'b0;
            cnt_reg <= '0;
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg - CNT_W'(1);
        end
    end

    assign tmr.busy = busy_reg;
    assign tmr.done = busy_reg && (cnt_reg == CNT_W'(1));
endmodule // op_timer

/* File: rtl/flash_write_erase_sequencer.sv */
// flash write/erase sequencer: apb registers, address map, block buffer
//
// Notes on behaviour
// - erase clears whole 1024-byte main page
// - scratchpad is 0x20000-0x200ff, two 128-byte pages
// - erase when enables set and byte written
// - scratch select plus 0x0400 erases both pages
// - scratch select maps low 256 addresses
// - instruction fetches never reach the scratchpad
// - bank field picks upper window bank
// - control bits sit at fixed positions
// - byte mode or four/two-byte block mode
// - block program uses single program time
// - byte mode write launches one program
// - code block buffered, programmed after 11b
// - scratch block programmed after 1b byte
// - redirect steers data writes to flash
// - busy flag high during any operation
// - data reads always go to ram
// - redirect bit cleared only by software
`timescale 1ns/1ps
module flash_write_erase_sequencer #(
    parameter logic [23:0] ERASE_CYCLES_P = flash_seq_pkg::ERASE_CYCLES,
    parameter logic [23:0] WRITE_CYCLES_P = flash_seq_pkg::WRITE_CYCLES
) (
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic DATA_WR_I,
    input wire logic DATA_RD_I,
    input wire logic [15:0] DATA_ADDR_I,
    input wire logic [7:0] DATA_WDATA_I,
    output logic RAM_WR_O,
    output logic RAM_RD_O,
    output logic CPU_WAIT_O,
    input wire logic CODE_RD_I,
    input wire logic CODE_FETCH_I,
    input wire logic [15:0] CODE_ADDR_I,
    output logic CODE_RD_O,
    output logic [17:0] CODE_LIN_ADDR_O,
    output logic FLASH_ERASE_O,
    output logic FLASH_ERASE_BOTH_O,
    output logic FLASH_PROG_O,
    output logic [17:0] FLASH_ADDR_O,
    output logic [31:0] FLASH_WDATA_O,
    output logic [3:0] FLASH_BYTE_EN_O,
    output logic FLASH_BUSY_O
);
    import flash_seq_pkg::*;

    op_timer_if tmr();

    logic [2:0] program_store_control_reg;
    logic sw_we_reg;
    logic block_reg;
    logic [1:0] bank_reg;
    logic [CNT_W-1:0] erase_cnt_reg;
    logic [CNT_W-1:0] write_cnt_reg;
    logic [31:0] prdata_reg;
    state_t state_reg;
    logic [31:0] buf_reg;
    logic [3:0] buf_en_reg;
    logic [17:0] fl_addr_reg;
    logic [31:0] fl_data_reg;
    logic [3:0] fl_en_reg;
    logic both_reg;
    logic code_rd_reg;
    logic [17:0] code_addr_reg;

    logic redirect;
    logic erase_en;
    logic scratch_sel;
    logic busy;
    logic apb_setup;
    logic apb_access;
    logic mapped;
    logic flash_wr;
    logic in_scratch;
    logic erase_go;
    logic erase_both;
    logic prog_go;
    logic blk_last;
    logic [17:0] lin_addr;
    logic [17:0] erase_addr;
    logic [31:0] merged;
    logic [3:0] merged_en;
    logic [31:0] lane_data;
    logic [3:0] lane_en;

    // -----------------------------------------------------------------
    // control bits
    // -----------------------------------------------------------------
    assign redirect = program_store_control_reg[REDIRECT_BIT];
    assign erase_en = program_store_control_reg[ERASE_EN_BIT];
    assign scratch_sel = program_store_control_reg[SCRATCH_BIT];
    assign busy = (state_reg != ST_IDLE);

    // -----------------------------------------------------------------
    // apb slave: zero wait states, error on unmapped offset
    // -----------------------------------------------------------------
    assign apb_setup = PSEL_I && !PENABLE_I;
    assign apb_access = PSEL_I && PENABLE_I;
    always_comb begin
        case (PADDR_I)
            OFS_PROGRAM_STORE_CONTROL, OFS_SCALE, OFS_CACHE, OFS_BANK,
            OFS_STATUS, OFS_ERASE_CNT, OFS_WRITE_CNT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = apb_access && !mapped;
    assign PRDATA_O = prdata_reg;

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            program_store_control_reg <= PROGRAM_STORE_CONTROL_RST;
            sw_we_reg <= SW_WE_RST;
            block_reg <= BLOCK_RST;
            bank_reg <= BANK_RST;
            erase_cnt_reg <= ERASE_CYCLES_P;
            write_cnt_reg <= WRITE_CYCLES_P;
        end else if (apb_access && PWRITE_I) begin
            // redirect changes only here, never by hardware
            case (PADDR_I)
                OFS_PROGRAM_STORE_CONTROL: program_store_control_reg <= PWDATA_I[2:0];
                OFS_SCALE: sw_we_reg <= PWDATA_I[SW_WE_BIT];
                OFS_CACHE: block_reg <= PWDATA_I[BLOCK_BIT];
                OFS_BANK: bank_reg <= PWDATA_I[BANK_LSB +: 2];
                OFS_ERASE_CNT: erase_cnt_reg <= PWDATA_I[CNT_W-1:0];
                OFS_WRITE_CNT: write_cnt_reg <= PWDATA_I[CNT_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            prdata_reg <= 32'h0;
        end else if (apb_setup) begin
            prdata_reg <= 32'h0;
            case (PADDR_I)
                OFS_PROGRAM_STORE_CONTROL: prdata_reg[2:0] <= program_store_control_reg;
                OFS_SCALE: prdata_reg[SW_WE_BIT] <= sw_we_reg;
                OFS_CACHE: prdata_reg[BLOCK_BIT] <= block_reg;
                OFS_BANK: prdata_reg[BANK_LSB +: 2] <= bank_reg;
                OFS_STATUS: prdata_reg[BUSY_BIT] <= busy;
                OFS_ERASE_CNT: prdata_reg[CNT_W-1:0] <= erase_cnt_reg;
                OFS_WRITE_CNT: prdata_reg[CNT_W-1:0] <= write_cnt_reg;
                default: ;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // data-space address map
    // -----------------------------------------------------------------
    assign in_scratch = scratch_sel && (DATA_ADDR_I[15:8] == SCRATCH_HI);
    always_comb begin
        if (in_scratch) begin
            lin_addr = SCRATCH_BASE | {10'h0, DATA_ADDR_I[7:0]};
        end else if (DATA_ADDR_I[15]) begin
            lin_addr = {1'b0, bank_reg, DATA_ADDR_I[14:0]};
        end else begin
            lin_addr = {3'b000, DATA_ADDR_I[14:0]};
        end
    end

    // ram sees reads always, writes only while not redirected
    assign RAM_RD_O = DATA_RD_I;
    assign RAM_WR_O = DATA_WR_I && !redirect;
    assign CPU_WAIT_O = busy;

    // write reaches flash only with both enables and an idle array
    assign flash_wr = DATA_WR_I && redirect && sw_we_reg && !busy;
    assign erase_go = flash_wr && erase_en;
    assign erase_both = scratch_sel && (DATA_ADDR_I == BOTH_PAGES_ADDR);
    always_comb begin
        if (erase_both) begin
            erase_addr = SCRATCH_BASE;
        end else if (in_scratch) begin
            erase_addr = lin_addr & SCRATCH_PAGE_MASK;
        end else begin
            erase_addr = lin_addr & MAIN_PAGE_MASK;
        end
    end

    // -----------------------------------------------------------------
    // byte lanes and block buffer
    // -----------------------------------------------------------------
    always_comb begin
        lane_data = {4{ERASED_BYTE}};
        lane_en = 4'h0;
        lane_data[DATA_ADDR_I[1:0]*8 +: 8] = DATA_WDATA_I;
        lane_en[DATA_ADDR_I[1:0]] = 1'b1;
    end

    // block closes on the 11b byte in code space, 1b in scratchpad
    assign blk_last = in_scratch ? DATA_ADDR_I[0] : (&DATA_ADDR_I[1:0]);
    always_comb begin
        merged = buf_reg;
        merged_en = buf_en_reg | lane_en;
        merged[DATA_ADDR_I[1:0]*8 +: 8] = DATA_WDATA_I;
        if (!block_reg) begin
            merged = lane_data;
            merged_en = lane_en;
        end
    end
    assign prog_go = flash_wr && !erase_en && (!block_reg || blk_last);

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            buf_reg <= {4{ERASED_BYTE}};
            buf_en_reg <= 4'h0;
        end else if (prog_go || !block_reg) begin
            buf_reg <= {4{ERASED_BYTE}};
            buf_en_reg <= 4'h0;
        end else if (flash_wr && !erase_en) begin
            buf_reg[DATA_ADDR_I[1:0]*8 +: 8] <= DATA_WDATA_I;
            buf_en_reg[DATA_ADDR_I[1:0]] <= 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // operation sequencing
    // -----------------------------------------------------------------
    assign tmr.start = erase_go || prog_go;
    // one program pulse per block, same length as a single byte
    assign tmr.cycles = erase_go ? erase_cnt_reg : write_cnt_reg;

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (erase_go) begin
                        state_reg <= ST_ERASE;
                    end else if (prog_go) begin
                        state_reg <= ST_PROG;
                    end
                end
                ST_ERASE, ST_PROG: begin
                    if (tmr.done) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            fl_addr_reg <= 18'h0;
            fl_data_reg <= {4{ERASED_BYTE}};
            fl_en_reg <= 4'h0;
            both_reg <= 1'b0;
        end else if (erase_go) begin
            fl_addr_reg <= erase_addr;
            fl_data_reg <= {4{ERASED_BYTE}};
            fl_en_reg <= 4'h0;
            both_reg <= erase_both;
        end else if (prog_go) begin
            fl_addr_reg <= lin_addr & WORD_MASK;
            fl_data_reg <= merged;
            fl_en_reg <= merged_en;
            both_reg <= 1'b0;
        end
    end

    assign FLASH_ERASE_O = (state_reg == ST_ERASE);
    assign FLASH_PROG_O = (state_reg == ST_PROG);
    assign FLASH_ERASE_BOTH_O = both_reg && (state_reg == ST_ERASE);
    assign FLASH_ADDR_O = fl_addr_reg;
    assign FLASH_WDATA_O = fl_data_reg;
    assign FLASH_BYTE_EN_O = fl_en_reg;
    assign FLASH_BUSY_O = busy;

    // -----------------------------------------------------------------
    // code-space reads; fetches bypass the scratchpad
    // -----------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            code_rd_reg <= 1'b0;
            code_addr_reg <= 18'h0;
        end else begin
            code_rd_reg <= CODE_RD_I;
            if (CODE_RD_I) begin
                if (scratch_sel && !CODE_FETCH_I && (CODE_ADDR_I[15:8] == SCRATCH_HI)) begin
                    code_addr_reg <= SCRATCH_BASE | {10'h0, CODE_ADDR_I[7:0]};
                end else if (CODE_ADDR_I[15]) begin
                    code_addr_reg <= {1'b0, bank_reg, CODE_ADDR_I[14:0]};
                end else begin
                    code_addr_reg <= {3'b000, CODE_ADDR_I[14:0]};
                end
            end
        end
    end
    assign CODE_RD_O = code_rd_reg;
    assign CODE_LIN_ADDR_O = code_addr_reg;

    op_timer u_timer (
        .SYS_CLK_I(SYS_CLK_I),
        .SYS_RST_I(SYS_RST_I),
        .tmr(tmr.timer)
    );
endmodule // flash_write_erase_sequencer

/* File: verif/flash_seq_asserts.sv */
// checker on the flash sequencer top ports
`timescale 1ns/1ps
module flash_seq_asserts #(
    parameter logic [23:0] ER_CYC = 24'h14,
    parameter logic [23:0] WR_CYC = 24'h5
) (
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic DATA_WR_I,
    input wire logic DATA_RD_I,
    input wire logic RAM_WR_O,
    input wire logic RAM_RD_O,
    input wire logic CPU_WAIT_O,
    input wire logic CODE_RD_I,
    input wire logic CODE_FETCH_I,
    input wire logic CODE_RD_O,
    input wire logic [17:0] CODE_LIN_ADDR_O,
    input wire logic FLASH_ERASE_O,
    input wire logic FLASH_ERASE_BOTH_O,
    input wire logic FLASH_PROG_O,
    input wire logic [17:0] FLASH_ADDR_O,
    input wire logic [31:0] FLASH_WDATA_O,
    input wire logic [3:0] FLASH_BYTE_EN_O,
    input wire logic FLASH_BUSY_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic er;
    logic [23:0] run;
    assign er = FLASH_ERASE_O | FLASH_ERASE_BOTH_O;
    // length of the current pulse
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            run <= 24'h0;
        end else begin
            run <= (FLASH_PROG_O || er) ? run + 24'h1 : 24'h0;
        end
    end
    a_prog_length: assert property ($fell(FLASH_PROG_O) |-> run == WR_CYC)
        else $error("program pulse length wrong");
    a_erase_length: assert property ($fell(er) |-> run == ER_CYC)
        else $error("erase pulse length wrong");
    a_busy_flag: assert property (FLASH_BUSY_O == (FLASH_PROG_O || er) && CPU_WAIT_O == FLASH_BUSY_O)
        else $error("busy does not follow operation");
    a_launch_cause: assert property ($rose(FLASH_BUSY_O) |-> $past(DATA_WR_I) && !$past(RAM_WR_O))
        else $error("operation without flash write");
    a_erase_blank: assert property ($rose(er) |-> FLASH_BYTE_EN_O == 4'h0 && FLASH_WDATA_O == 32'hffffffff)
        else $error("erase not blank");
    a_page_base: assert property ($rose(er) |-> FLASH_ADDR_O[6:0] == 7'h0 && (FLASH_ADDR_O[17] || FLASH_ADDR_O[9:7] == 3'h0))
        else $error("erase address not page base");
    a_prog_word: assert property ($rose(FLASH_PROG_O) |-> FLASH_ADDR_O[1:0] == 2'h0 && FLASH_BYTE_EN_O != 4'h0)
        else $error("program not word aligned");
    a_ram_read: assert property (RAM_RD_O == DATA_RD_I)
        else $error("data read not sent to ram");
    a_fetch_main: assert property (CODE_RD_I && CODE_FETCH_I |=> CODE_RD_O && !CODE_LIN_ADDR_O[17])
        else $error("fetch reached scratchpad");
    c_block: cover property ($rose(FLASH_PROG_O) && FLASH_BYTE_EN_O == 4'hf);
    c_both: cover property ($rose(FLASH_ERASE_BOTH_O));
    c_scratch: cover property ($rose(FLASH_PROG_O) && FLASH_ADDR_O[17]);
endmodule // flash_seq_asserts

bind flash_write_erase_sequencer flash_seq_asserts #(
    .ER_CYC(ERASE_CYCLES_P), .WR_CYC(WRITE_CYCLES_P)
) i_flash_seq_asserts (
    .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .DATA_WR_I(DATA_WR_I),
    .DATA_RD_I(DATA_RD_I), .RAM_WR_O(RAM_WR_O), .RAM_RD_O(RAM_RD_O), .CPU_WAIT_O(CPU_WAIT_O),
    .CODE_RD_I(CODE_RD_I), .CODE_FETCH_I(CODE_FETCH_I), .CODE_RD_O(CODE_RD_O),
    .CODE_LIN_ADDR_O(CODE_LIN_ADDR_O), .FLASH_ERASE_O(FLASH_ERASE_O),
    .FLASH_ERASE_BOTH_O(FLASH_ERASE_BOTH_O), .FLASH_PROG_O(FLASH_PROG_O),
    .FLASH_ADDR_O(FLASH_ADDR_O), .FLASH_WDATA_O(FLASH_WDATA_O),
    .FLASH_BYTE_EN_O(FLASH_BYTE_EN_O), .FLASH_BUSY_O(FLASH_BUSY_O)
);

/* File: verif/cpu_model.sv */
// cpu core model issuing data-space and code-space accesses
`timescale 1ns/1ps
module cpu_model (
    input wire logic clk_i,
    input wire logic wait_i,
    output logic data_wr_o,
    output logic data_rd_o,
    output logic [15:0] data_addr_o,
    output logic [7:0] data_wdata_o,
    output logic code_rd_o,
    output logic code_fetch_o,
    output logic [15:0] code_addr_o
);
    initial begin
        data_wr_o = 1'b0;
        data_rd_o = 1'b0;
        data_addr_o = 16'h0;
        data_wdata_o = 8'h0;
        code_rd_o = 1'b0;
        code_fetch_o = 1'b0;
        code_addr_o = 16'h0;
    end
    // one data-space move, held off while an operation runs
    task automatic data_move(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        while (wait_i !== 1'b0) @(posedge clk_i);
        data_wr_o <= wr;
        data_rd_o <= !wr;
        data_addr_o <= a;
        data_wdata_o <= d;
        @(posedge clk_i);
        data_wr_o <= 1'b0;
        data_rd_o <= 1'b0;
        data_addr_o <= ~a;
        data_wdata_o <= ~d;
    endtask
    task automatic code_read(input logic [15:0] a, input logic fetch);
        @(posedge clk_i);
        code_rd_o <= 1'b1;
        code_fetch_o <= fetch;
        code_addr_o <= a;
        @(posedge clk_i);
        code_rd_o <= 1'b0;
        code_fetch_o <= !fetch;
        code_addr_o <= ~a;
    endtask
endmodule // cpu_model

/* File: verif/testbench.sv */
// self-checking bench of the flash write/erase sequencer
`timescale 1ns/1ps
module testbench;
    import flash_seq_pkg::*;
    localparam int ER = 20;
    localparam int WR = 5;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, slverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata, fwdata;
    logic dwr, drd, cfetch, crd_i, ramwr, ramrd, cwait, crd, erase, both, prog, busy;
    logic [15:0] daddr, caddr;
    logic [7:0] dwdata;
    logic [17:0] clin, faddr;
    logic [3:0] fen;
    int fails = 0;
    int n_compared = 0;
    int n_ram = 0;
    int n_rd = 0;

    flash_write_erase_sequencer #(.ERASE_CYCLES_P(24'(ER)), .WRITE_CYCLES_P(24'(WR)))
    i_flash_write_erase_sequencer (
        .SYS_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .DATA_WR_I(dwr), .DATA_RD_I(drd),
        .DATA_ADDR_I(daddr), .DATA_WDATA_I(dwdata), .RAM_WR_O(ramwr), .RAM_RD_O(ramrd),
        .CPU_WAIT_O(cwait), .CODE_RD_I(crd_i), .CODE_FETCH_I(cfetch), .CODE_ADDR_I(caddr),
        .CODE_RD_O(crd), .CODE_LIN_ADDR_O(clin), .FLASH_ERASE_O(erase),
        .FLASH_ERASE_BOTH_O(both), .FLASH_PROG_O(prog), .FLASH_ADDR_O(faddr),
        .FLASH_WDATA_O(fwdata), .FLASH_BYTE_EN_O(fen), .FLASH_BUSY_O(busy));
    cpu_model i_cpu_model (.clk_i(clk), .wait_i(cwait), .data_wr_o(dwr), .data_rd_o(drd),
        .data_addr_o(daddr), .data_wdata_o(dwdata), .code_rd_o(crd_i),
        .code_fetch_o(cfetch), .code_addr_o(caddr));

    // ----------------------------------------------------------------
    // clock, reset, monitors
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (ramwr === 1'b1) n_ram++;
        if (ramrd === 1'b1) n_rd++;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdata = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        i_cpu_model.data_move(1'b1, a, d);
    endtask
    // launched operation: kind, address, lanes, then its length
    task automatic op(input logic ers, input logic bth, input int len, input logic [17:0] a,
                      input logic [31:0] wd, input logic [3:0] en);
        int n;
        n = 0;
        #1;
        chk(prog, !ers);
        chk(erase | both, ers);
        chk(both, bth);
        chk(faddr, a);
        chk(fwdata, wd);
        chk(fen, en);
        while (busy === 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, len);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        apb(1'b0, OFS_BANK, 32'h0);
        chk(rdata, {26'h0, BANK_RST, 4'h0});
        apb(1'b0, OFS_ERASE_CNT, 32'h0);
        chk(rdata, 32'(ER));
        apb(1'b1, OFS_WRITE_CNT, 32'h3);
        apb(1'b0, OFS_WRITE_CNT, 32'h0);
        chk(rdata, 32'h3);
        apb(1'b1, OFS_WRITE_CNT, 32'(WR));
        apb(1'b0, 8'h40, 32'h0);
        chk(slverr, 1'b1);
        apb(1'b1, OFS_PROGRAM_STORE_CONTROL, 32'h7);
        apb(1'b0, OFS_PROGRAM_STORE_CONTROL, 32'h0);
        chk(rdata, 32'h7);
        apb(1'b1, OFS_PROGRAM_STORE_CONTROL, 32'h0);
    endtask
    task automatic t_ram;
        wr(16'h1234, 8'h11);
        #1;
        chk(n_ram, 1);
        chk(busy, 1'b0);
        apb(1'b1, OFS_PROGRAM_STORE_CONTROL, 32'h1);
        wr(16'h1234, 8'h22);
        #1;
        chk(n_ram, 1);
        chk(busy, 1'b0);
        i_cpu_model.data_move(1'b0, 16'h0040, 8'h0);
        #1;
        chk(n_rd, 1);
        apb(1'b1, OFS_SCALE, 32'h1);
    endtask
    task automatic t_erase;
        apb(1'b1, OFS_PROGRAM_STORE_CONTROL, 32'h3);
        wr(16'h0c37, 8'h00);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rdata, 32'h1);
        while (busy === 1'b1) @(posedge clk);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rdata, 32'h0);
        wr(16'h0c37, 8'h00);
        op(1'b1, 1'b0, ER, 18'h00c00, 32'hffffffff, 4'h0);
        apb(1'b1, OFS_PROGRAM_STORE_CONTROL, 32'h7);
        wr(16'h00a5, 8'h00);
        op(1'b1, 1'b0, ER, 18'h20080, 32'hffffffff, 4'h0);
        wr(BOTH_PAGES_ADDR, 8'h00);
        op(1'b1, 1'b1, ER, SCRATCH_BASE, 32'hffffffff, 4'h0);
        apb(1'b0, OFS_PROGRAM_STORE_CONTROL, 32'h0);
        chk(rdata, 32'h7);
        apb(1'b1, OFS_PROGRAM_STORE_CONTROL, 32'h1);
    endtask
    task automatic t_single;
        for (int b = 0; b < 4; b++) begin
            apb(1'b1, OFS_BANK, 32'(b) << BANK_LSB);
            wr(16'h8405, 8'h5a);
            op(1'b0, 1'b0, WR, {1'b0, 2'(b), 15'h0404}, 32'hffff5aff, 4'h2);
        end
        apb(1'b1, OFS_BANK, 32'h10);
        wr(16'h0407, 8'h3c);
        op(1'b0, 1'b0, WR, 18'h00404, 32'h3cffffff, 4'h8);
    endtask
    task automatic t_block;
        logic [7:0] d;
        apb(1'b1, OFS_CACHE, 32'h1);
        for (int i = 0; i < 3; i++) begin
            d = (i == 0) ? 8'hff : 8'(i * 17 + 17);
            wr(16'h2000 + 16'(i), d);
            #1;
            chk(busy, 1'b0);
        end
        wr(16'h2003, 8'h44);
        op(1'b0, 1'b0, WR, 18'h02000, 32'h443322ff, 4'hf);
        apb(1'b1, OFS_PROGRAM_STORE_CONTROL, 32'h5);
        wr(16'h0080, 8'haa);
        #1;
        chk(busy, 1'b0);
        wr(16'h0081, 8'hbb);
        op(1'b0, 1'b0, WR, 18'h20080, 32'hffffbbaa, 4'h3);
        apb(1'b1, OFS_CACHE, 32'h0);
    endtask
    task automatic t_code;
        apb(1'b1, OFS_PROGRAM_STORE_CONTROL, 32'h4);
        i_cpu_model.code_read(16'h0010, 1'b0);
        #1;
        chk(crd, 1'b1);
        chk(clin, 18'h20010);
        i_cpu_model.code_read(16'h0010, 1'b1);
        #1;
        chk(clin, 18'h00010);
        apb(1'b1, OFS_BANK, 32'h30);
        i_cpu_model.code_read(16'h9000, 1'b0);
        #1;
        chk(clin, 18'h19000);
        wr(16'h1234, 8'h33);
        #1;
        chk(n_ram, 2);
    endtask

    // ----------------------------------------------------------------
    // sequence and verdict
    // ----------------------------------------------------------------
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_ram();
        t_erase();
        t_single();
        t_block();
        t_code();
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        give_verdict();
    end
endmodule // testbench
